// ---- core/ssr_unit.sv ----
// Status reporting unit: two filtered status registers, event status, status byte
//
// Behaviour
// (RQ1) Five parts per register, sixteen bits each
// (RQ2) Bit fifteen of every part reads zero
// (RQ3) One bit per source, positions independent
// (RQ4) Condition follows hardware or lower sum bit
// (RQ5) Condition is read-only, unaffected by reads
// (RQ6) Rising condition sets event if rising-filter set
// (RQ7) Falling condition sets event if falling-filter set
// (RQ8) Both filters read/write, reads harmless
// (RQ9) Event part latches only filtered edges, read-only
// (RQ10) Reading event part returns then clears it
// (RQ11) Sum bit is OR of event AND enable
// (RQ12) Enable part read/write, reads harmless
// (RQ13) Sum bits feed next higher condition bit
// (RQ14) Message-available bit mirrors output queue occupancy
// (RQ15) Error queue keeps entries, returns oldest first
// (RQ16) Request and event enables mask status byte, ESR
// (RQ17) Enabled status-byte rise requests service; enable bit6 ignored
// (RQ18) Edge during event read survives the clear
// (RQ19) Reset clears events and edge history
`timescale 1ns/1ps
module ssr_unit
	import ssr_pkg::*;
#(
	parameter int unsigned ERR_W  = 16,
	parameter int unsigned ERR_AW = 4
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [14:0]      ques_cond,
	input  wire logic [14:0]      oper_cond,
	input  wire logic [7:0]       std_evt,
	input  wire logic             out_queue_avail,
	input  wire logic             err_push,
	input  wire logic [ERR_W-1:0] err_code,
	input  wire logic             cmd_valid,
	input  wire logic             cmd_write,
	input  wire logic [4:0]       cmd_addr,
	input  wire logic [15:0]      cmd_wdata,
	output logic                  rsp_valid,
	output logic      [15:0]      rsp_data,
	output logic      [7:0]       status_byte,
	output logic                  srq,
	output logic                  err_full
);
	import ssr_pkg::*;

	logic [1:0]  blk;
	logic [2:0]  part;
	logic        is_rd;
	logic        is_wr;
	logic        sel_ques;
	logic        sel_oper;
	logic        sel_ieee;
	logic        q_wr_ptr;
	logic        q_wr_ntr;
	logic        q_wr_en;
	logic        q_rd_evt;
	logic        o_wr_ptr;
	logic        o_wr_ntr;
	logic        o_wr_en;
	logic        o_rd_evt;
	logic        wr_ese;
	logic        wr_sre;

	logic [15:0] q_cond;
	logic [15:0] q_ptr;
	logic [15:0] q_ntr;
	logic [15:0] q_evt;
	logic [15:0] q_en;
	logic        q_sum;
	logic [15:0] o_cond;
	logic [15:0] o_ptr;
	logic [15:0] o_ntr;
	logic [15:0] o_evt;
	logic [15:0] o_en;
	logic        o_sum;

	logic [7:0]  esr_q;
	logic [7:0]  esr_d;
	logic [7:0]  ese_q;
	logic [7:0]  sre_q;
	logic        rd_esr;
	logic        esb;

	logic [7:0]  stb_raw;
	logic [7:0]  stb_armed;
	logic [7:0]  stb_prev_q;
	logic        mss;
	logic        srq_q;

	logic        errq_pop;
	logic        errq_empty;
	logic [ERR_W-1:0] errq_head;

	logic [15:0] rd_mux;
	logic [15:0] rsp_data_q;
	logic        rsp_valid_q;

	// Address decode
	assign blk      = cmd_addr[4:3];
	assign part     = cmd_addr[2:0];
	assign is_rd    = cmd_valid && !cmd_write;
	assign is_wr    = cmd_valid && cmd_write;
	assign sel_ques = (blk == BLK_QUES);
	assign sel_oper = (blk == BLK_OPER);
	assign sel_ieee = (blk == BLK_IEEE);

	// Part strobes; read-only parts get no write strobe at all
	assign q_wr_ptr = is_wr && sel_ques && (part == PART_PTR); // RQ8
	assign q_wr_ntr = is_wr && sel_ques && (part == PART_NTR); // RQ8
	assign q_wr_en  = is_wr && sel_ques && (part == PART_EN); // RQ12
	assign q_rd_evt = is_rd && sel_ques && (part == PART_EVT);
	assign o_wr_ptr = is_wr && sel_oper && (part == PART_PTR); // RQ8
	assign o_wr_ntr = is_wr && sel_oper && (part == PART_NTR); // RQ8
	assign o_wr_en  = is_wr && sel_oper && (part == PART_EN); // RQ12
	assign o_rd_evt = is_rd && sel_oper && (part == PART_EVT);
	assign wr_ese   = is_wr && sel_ieee && (part == IEEE_ESE);
	assign wr_sre   = is_wr && sel_ieee && (part == IEEE_SRE);

	// Questionable register: its conditions come straight from hardware
	ssr_scpi_reg u_ques ( // RQ1
		.clk    (clk),
		.resetn (resetn),
		.cond   (ques_cond), // RQ4
		.wdata  (cmd_wdata),
		.wr_ptr (q_wr_ptr),
		.wr_ntr (q_wr_ntr),
		.wr_en  (q_wr_en),
		.rd_evt (q_rd_evt), // RQ10
		.cond_o (q_cond),
		.ptr_q  (q_ptr),
		.ntr_q  (q_ntr),
		.evt_q  (q_evt),
		.en_q   (q_en),
		.sum    (q_sum)
	);

	// Operation register
	ssr_scpi_reg u_oper ( // RQ1
		.clk    (clk),
		.resetn (resetn),
		.cond   (oper_cond),
		.wdata  (cmd_wdata),
		.wr_ptr (o_wr_ptr),
		.wr_ntr (o_wr_ntr),
		.wr_en  (o_wr_en),
		.rd_evt (o_rd_evt), // RQ10
		.cond_o (o_cond),
		.ptr_q  (o_ptr),
		.ntr_q  (o_ntr),
		.evt_q  (o_evt),
		.en_q   (o_en),
		.sum    (o_sum)
	);

	// Error queue; a read pops the oldest entry
	assign errq_pop = is_rd && sel_ieee && part == IEEE_ERRQ; // RQ15

	ssr_err_mem #(
		.W  (ERR_W),
		.AW (ERR_AW)
	) u_errq (
		.clk       (clk),
		.resetn    (resetn),
		.push      (err_push),
		.push_data (err_code),
		.pop       (errq_pop),
		.head_q    (errq_head),
		.empty     (errq_empty),
		.full      (err_full)
	);

	// Standard event status: sources pulse, a read clears, a new pulse wins
	assign rd_esr = is_rd && sel_ieee && part == IEEE_ESR;
	assign esr_d  = ((rd_esr ? ESR_RST : esr_q) | std_evt) & ESR_USED; // RQ18
	assign esb    = |(esr_q & ese_q); // RQ16

	// Status byte collects the sum bits of the lower registers
	always_comb
	begin
		stb_raw           = STB_RST;
		stb_raw[STB_ERRQ] = !errq_empty;
		stb_raw[STB_QUES] = q_sum; // RQ13
		stb_raw[STB_MAV]  = out_queue_avail; // RQ14
		stb_raw[STB_ESB]  = esb; // RQ13
		stb_raw[STB_OPER] = o_sum; // RQ13
	end

	// Bit 6 of the request enable is masked off: it is the summary itself
	assign stb_armed   = stb_raw & sre_q & SRE_USED; // RQ16 RQ17
	assign mss         = |stb_armed;
	assign status_byte = {stb_raw[7], mss, stb_raw[5:0]};

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			esr_q      <= ESR_RST;
			ese_q      <= ESE_RST;
			sre_q      <= SRE_RST;
			stb_prev_q <= STB_RST;
			srq_q      <= 1'b0;
		end
		else
		begin
			esr_q      <= esr_d;
			ese_q      <= wr_ese ? cmd_wdata[7:0] : ese_q;
			sre_q      <= wr_sre ? cmd_wdata[7:0] : sre_q;
			stb_prev_q <= stb_armed;
			srq_q      <= |(stb_armed & ~stb_prev_q); // RQ17
		end
	end

	assign srq = srq_q;

	// Read data; writes to read-only parts are simply not decoded
	always_comb
	begin
		rd_mux = RSP_RST;
		if (sel_ques)
		begin
			case (part)
				PART_COND: rd_mux = q_cond; // RQ5
				PART_PTR:  rd_mux = q_ptr;
				PART_NTR:  rd_mux = q_ntr;
				PART_EVT:  rd_mux = q_evt;
				PART_EN:   rd_mux = q_en;
				default:   rd_mux = RSP_RST;
			endcase
		end
		else if (sel_oper)
		begin
			case (part)
				PART_COND: rd_mux = o_cond;
				PART_PTR:  rd_mux = o_ptr;
				PART_NTR:  rd_mux = o_ntr;
				PART_EVT:  rd_mux = o_evt;
				PART_EN:   rd_mux = o_en;
				default:   rd_mux = RSP_RST;
			endcase
		end
		else if (sel_ieee)
		begin
			case (part)
				IEEE_ESR:  rd_mux = {8'h00, esr_q};
				IEEE_ESE:  rd_mux = {8'h00, ese_q};
				IEEE_STB:  rd_mux = {8'h00, status_byte};
				IEEE_SRE:  rd_mux = {8'h00, sre_q};
				IEEE_ERRQ: rd_mux = errq_empty ? ERRQ_EMPTY : 16'(errq_head);
				default:   rd_mux = RSP_RST;
			endcase
		end
	end

	// Every read is answered one cycle later, value taken before any clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rsp_valid_q <= 1'b0;
			rsp_data_q  <= RSP_RST;
		end
		else
		begin
			rsp_valid_q <= is_rd;
			rsp_data_q  <= is_rd ? (rd_mux & PART_MASK) : rsp_data_q; // RQ2
		end
	end

	assign rsp_valid = rsp_valid_q;
	assign rsp_data  = rsp_data_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_armed_rise;
		(stb_armed & ~stb_prev_q) != 8'h00;
	endsequence

	sequence s_quiet;
		(stb_armed & ~stb_prev_q) == 8'h00;
	endsequence

	chk_srq_on_rise: assert property (s_armed_rise |=> srq) // RQ17
		else $error("service request missing after enabled rise");
	chk_srq_only_rise: assert property (s_quiet |=> !srq) // RQ17
		else $error("service request without enabled rise");
	// Expected summary is built from the output bits, leaving bit 6 out
	chk_sre6_ignored: assert property ( // RQ17
		status_byte[STB_MSS] ==
		((|(status_byte[5:0] & sre_q[5:0])) || (status_byte[7] && sre_q[7])))
		else $error("summary does not follow enabled status bits");
	chk_esr_set_wins: assert property ( // RQ18
		(rd_esr && (std_evt & ESR_USED) != 8'h00)
		|=> ((esr_q & $past(std_evt & ESR_USED)) == $past(std_evt & ESR_USED)))
		else $error("event lost during status read");
	chk_read_answer: assert property ( // RQ10
		is_rd |=> rsp_valid && rsp_data == $past(rd_mux & PART_MASK))
		else $error("read answer wrong or late");
	chk_cond_steady: assert property ( // RQ5
		(is_wr && sel_ques && part == PART_COND)
		|=> (q_ptr == $past(q_ptr)) && (q_ntr == $past(q_ntr)) && (q_en == $past(q_en))
			&& (rsp_data == $past(rsp_data)) && !rsp_valid)
		else $error("condition write disturbed another part");
	chk_cond_read: assert property ( // RQ4 RQ5
		(is_rd && sel_ques && part == PART_COND) |=> rsp_data == {1'b0, $past(ques_cond)})
		else $error("condition read does not show the live sources");
	chk_mav_follow: assert property (status_byte[STB_MAV] == out_queue_avail) // RQ14
		else $error("message available bit wrong");
	chk_stb_unused: assert property (status_byte[1:0] == 2'b00) // RQ13
		else $error("unused status byte bit set");
	chk_evt_answer: assert property ( // RQ10
		q_rd_evt |=> rsp_data == ($past(q_evt) & PART_MASK))
		else $error("event read answer wrong");

	sequence s_esr_read_quiet;
		rd_esr && (std_evt & ESR_USED) == 8'h00;
	endsequence

	chk_esr_read_clears: assert property (s_esr_read_quiet |=> esr_q == ESR_RST) // RQ16
		else $error("event status not cleared by read");
	chk_sum_to_stb: assert property ( // RQ11 RQ13
		status_byte[STB_QUES] == (|(q_evt & q_en)) && status_byte[STB_OPER] == (|(o_evt & o_en)))
		else $error("summary bit does not follow event and enable");
	chk_rsp_only_read: assert property (!is_rd |=> !rsp_valid) // RQ10
		else $error("read answer without a read");
	chk_ese_write: assert property (wr_ese |=> ese_q == $past(cmd_wdata[7:0])) // RQ16
		else $error("event status enable write lost");
	chk_sre_write: assert property (wr_sre |=> sre_q == $past(cmd_wdata[7:0])) // RQ16
		else $error("request enable write lost");

	// Queue occupancy checks
	sequence s_push_room;
		err_push && !err_full;
	endsequence

	chk_errq_takes: assert property (s_push_room |=> !errq_empty) // RQ15
		else $error("error queue dropped an entry with room");
	chk_errq_frees: assert property ( // RQ15
		(errq_pop && !errq_empty && !err_push) |=> !err_full)
		else $error("error queue still full after a pop");
endmodule // ssr_unit

// ---- core/ssr_pkg.sv ----
// Constants shared by the status reporting unit: parts, map, reset values
package ssr_pkg;

	localparam int unsigned PART_W     = 16;
	localparam logic [15:0] PART_MASK  = 16'h7fff;
	localparam logic [15:0] PTR_RST    = 16'h7fff;
	localparam logic [15:0] NTR_RST    = 16'h0000;
	localparam logic [15:0] EN_RST     = 16'h0000;
	localparam logic [15:0] EVT_RST    = 16'h0000;
	localparam logic [15:0] HIST_RST   = 16'h0000;

	// Command address is {block, part}
	localparam logic [1:0]  BLK_QUES   = 2'h0;
	localparam logic [1:0]  BLK_OPER   = 2'h1;
	localparam logic [1:0]  BLK_IEEE   = 2'h2;
	localparam logic [2:0]  PART_COND  = 3'h0;
	localparam logic [2:0]  PART_PTR   = 3'h1;
	localparam logic [2:0]  PART_NTR   = 3'h2;
	localparam logic [2:0]  PART_EVT   = 3'h3;
	localparam logic [2:0]  PART_EN    = 3'h4;
	localparam logic [2:0]  IEEE_ESR   = 3'h0;
	localparam logic [2:0]  IEEE_ESE   = 3'h1;
	localparam logic [2:0]  IEEE_STB   = 3'h2;
	localparam logic [2:0]  IEEE_SRE   = 3'h3;
	localparam logic [2:0]  IEEE_ERRQ  = 3'h4;

	localparam int unsigned STB_ERRQ   = 2;
	localparam int unsigned STB_QUES   = 3;
	localparam int unsigned STB_MAV    = 4;
	localparam int unsigned STB_ESB    = 5;
	localparam int unsigned STB_MSS    = 6;
	localparam int unsigned STB_OPER   = 7;
	localparam logic [7:0]  SRE_USED   = 8'hbf;
	localparam logic [7:0]  ESR_USED   = 8'hfd;
	localparam logic [7:0]  ESR_RST    = 8'h00;
	localparam logic [7:0]  ESE_RST    = 8'h00;
	localparam logic [7:0]  SRE_RST    = 8'h00;
	localparam logic [7:0]  STB_RST    = 8'h00;
	localparam logic [15:0] RSP_RST    = 16'h0000;
	localparam logic [15:0] ERRQ_EMPTY = 16'h0000;

endpackage

// ---- core/ssr_err_mem.sv ----
// Error queue storage: oldest-first FIFO with registered head word
`timescale 1ns/1ps
module ssr_err_mem #(
	parameter int unsigned W  = 16,
	parameter int unsigned AW = 4
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         push,
	input  wire logic [W-1:0] push_data,
	input  wire logic         pop,
	output logic      [W-1:0] head_q,
	output logic              empty,
	output logic              full
);
	logic [W-1:0]  mem [2**AW];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          do_push;
	logic          do_pop;
	logic [AW-1:0] rd_d;

	// A full queue drops new entries so the oldest ones survive
	assign full    = cnt_q[AW];
	assign empty   = (cnt_q == '0);
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;
	assign rd_d    = do_pop ? rd_q + 1'b1 : rd_q;

	always_ff @(posedge clk)
	begin
		if (do_push)
			mem[wr_q] <= push_data;
	end

	// Head is re-read every cycle; bypass covers a push into the head slot
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_q   <= '0;
			rd_q   <= '0;
			cnt_q  <= '0;
			head_q <= '0;
		end
		else
		begin
			wr_q   <= do_push ? wr_q + 1'b1 : wr_q;
			rd_q   <= rd_d;
			cnt_q  <= cnt_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
			head_q <= (do_push && wr_q == rd_d) ? push_data : mem[rd_d];
		end
	end
endmodule // ssr_err_mem

// ---- core/ssr_scpi_reg.sv ----
// One five-part status register with transition filters and sum bit
`timescale 1ns/1ps
module ssr_scpi_reg
	import ssr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [14:0] cond,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_ptr,
	input  wire logic        wr_ntr,
	input  wire logic        wr_en,
	input  wire logic        rd_evt,
	output logic      [15:0] cond_o,
	output logic      [15:0] ptr_q,
	output logic      [15:0] ntr_q,
	output logic      [15:0] evt_q,
	output logic      [15:0] en_q,
	output logic             sum
);
	logic [15:0] hist_q;
	logic        primed_q;
	logic [15:0] rise;
	logic [15:0] fall;
	logic [15:0] hits;
	logic [15:0] evt_d;

	assign cond_o = {1'b0, cond}; // RQ4 RQ5 RQ2
	// No edge is seen until history holds a real sample
	assign rise   = primed_q ? (cond_o & ~hist_q) : 16'h0000; // RQ19
	assign fall   = primed_q ? (~cond_o & hist_q) : 16'h0000;
	assign hits   = ((rise & ptr_q) | (fall & ntr_q)) & PART_MASK; // RQ3 RQ6 RQ7
	assign evt_d  = (rd_evt ? EVT_RST : evt_q) | hits; // RQ9 RQ10 RQ18
	assign sum    = |(evt_q & en_q); // RQ11

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ptr_q    <= PTR_RST;
			ntr_q    <= NTR_RST;
			en_q     <= EN_RST;
			evt_q    <= EVT_RST;
			hist_q   <= HIST_RST;
			primed_q <= 1'b0;
		end
		else
		begin
			ptr_q    <= wr_ptr ? (wdata & PART_MASK) : ptr_q; // RQ8 RQ2
			ntr_q    <= wr_ntr ? (wdata & PART_MASK) : ntr_q; // RQ8
			en_q     <= wr_en ? (wdata & PART_MASK) : en_q; // RQ12
			evt_q    <= evt_d;
			hist_q   <= cond_o;
			primed_q <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_rise_latches: assert property ( // RQ6
		(primed_q && (cond_o & ~hist_q & ptr_q) != 0)
		|=> ((evt_q & $past(cond_o & ~hist_q & ptr_q)) == $past(cond_o & ~hist_q & ptr_q)))
		else $error("filtered rising edge not latched");
	chk_fall_blocked: assert property ( // RQ7
		(!rd_evt && hits == 0) |=> (evt_q == $past(evt_q)))
		else $error("event part changed without a passed edge");
	chk_read_clears: assert property ( // RQ10
		(rd_evt && hits == 0) |=> (evt_q == 16'h0000))
		else $error("event part not cleared by read");
	chk_msb_zero: assert property ( // RQ2
		!ptr_q[15] && !ntr_q[15] && !en_q[15] && !evt_q[15] && !cond_o[15])
		else $error("bit 15 of a part is set");
endmodule // ssr_scpi_reg

// ---- dv/ssr_ctrl_model.sv ----
// Controller model: issues status commands and collects read answers
`timescale 1ns/1ps
module ssr_ctrl_model (
	input  wire logic        clk,
	output logic             cmd_valid,
	output logic             cmd_write,
	output logic [4:0]       cmd_addr,
	output logic [15:0]      cmd_wdata,
	input  wire logic        rsp_valid,
	input  wire logic [15:0] rsp_data
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr  = 5'h00;
		cmd_wdata = 16'h0000;
	end

	// One command, taken at the rising edge; a read answer is due one cycle later
	task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d,
		output logic [15:0] r);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_addr  = a;
		cmd_wdata = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		// Idle qualifiers are scrambled so nothing leans on stale values
		cmd_write = ~wr;
		cmd_addr  = ~a;
		cmd_wdata = ~d;
		r = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx;
	endtask
endmodule // ssr_ctrl_model

// ---- dv/tb_ssr_unit.sv ----
// Testbench for the status reporting unit
`timescale 1ns/1ps
module tb_ssr_unit;
	import ssr_pkg::*;
	localparam logic [4:0] QC = {BLK_QUES, PART_COND};
	localparam logic [4:0] QP = {BLK_QUES, PART_PTR};
	localparam logic [4:0] QN = {BLK_QUES, PART_NTR};
	localparam logic [4:0] QE = {BLK_QUES, PART_EVT};
	localparam logic [4:0] QM = {BLK_QUES, PART_EN};
	localparam logic [4:0] OC = {BLK_OPER, PART_COND};
	localparam logic [4:0] OE = {BLK_OPER, PART_EVT};
	localparam logic [4:0] OM = {BLK_OPER, PART_EN};
	localparam logic [4:0] ES = {BLK_IEEE, IEEE_ESR};
	localparam logic [4:0] EE = {BLK_IEEE, IEEE_ESE};
	localparam logic [4:0] SB = {BLK_IEEE, IEEE_STB};
	localparam logic [4:0] SR = {BLK_IEEE, IEEE_SRE};
	localparam logic [4:0] EQ = {BLK_IEEE, IEEE_ERRQ};

	logic        clk;
	logic        resetn;
	logic [14:0] ques_cond;
	logic [14:0] oper_cond;
	logic [7:0]  std_evt;
	logic        out_queue_avail;
	logic        err_push;
	logic [15:0] err_code;
	logic        cmd_valid;
	logic        cmd_write;
	logic [4:0]  cmd_addr;
	logic [15:0] cmd_wdata;
	logic        rsp_valid;
	logic [15:0] rsp_data;
	logic [7:0]  status_byte;
	logic        srq;
	logic        err_full;
	logic [15:0] r;
	logic        seen;
	int          failures;
	int          checked;
	int          cycles;

	ssr_unit i_ssr_unit (.clk(clk), .resetn(resetn), .ques_cond(ques_cond),
		.oper_cond(oper_cond), .std_evt(std_evt), .out_queue_avail(out_queue_avail),
		.err_push(err_push), .err_code(err_code), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .status_byte(status_byte),
		.srq(srq), .err_full(err_full));

	ssr_ctrl_model i_ssr_ctrl_model (.clk(clk), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic finish_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
		checked++;
		if (seen_v !== exp_v)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask

	task automatic bit_is(input logic b, input logic e);
		check({15'h0000, b}, {15'h0000, e});
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		i_ssr_ctrl_model.xfer(1'b0, a, 16'h0000, r);
		check(r, e);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		i_ssr_ctrl_model.xfer(1'b1, a, d, r);
	endtask

	// Hang guard: the full sequence needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			failures++;
			finish_test();
		end
	end

	initial
	begin
		resetn = 1'b0;
		ques_cond = 15'h0004;
		oper_cond = 15'h7fff;
		std_evt = 8'h00;
		out_queue_avail = 1'b0;
		err_push = 1'b0;
		err_code = 16'h0000;
		failures = 0;
		checked = 0;
		cycles = 0;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		// A level high through reset must not be taken as an edge
		rd(QE, EVT_RST);
		rd(QP, PTR_RST);
		rd(QN, NTR_RST);
		rd(QM, EN_RST);
		rd(QC, 16'h0004);
		rd(OC, 16'h7fff);
		wr(QP, 16'hffff);
		rd(QP, 16'h7fff);
		rd(QP, 16'h7fff);
		wr(QM, 16'hffff);
		rd(QM, 16'h7fff);
		wr(QC, 16'h1234);
		rd(QC, 16'h0004);
		wr(QP, 16'h0001);
		wr(QN, 16'h0002);
		wr(QM, 16'h0000);
		ques_cond = 15'h0007;
		repeat (3) @(negedge clk);
		rd(QE, 16'h0001);
		rd(QE, 16'h0000);
		ques_cond = 15'h0004;
		repeat (3) @(negedge clk);
		wr(QM, 16'h0002);
		bit_is(status_byte[STB_QUES], 1'b1);
		wr(QM, 16'h0001);
		bit_is(status_byte[STB_QUES], 1'b0);
		rd(QE, 16'h0002);
		// Service request via the questionable sum; enable bit6 set but ignored
		wr(SR, 16'h0048);
		seen = 1'b0;
		ques_cond = 15'h0005;
		repeat (5)
		begin
			@(negedge clk);
			seen = seen | (srq === 1'b1);
		end
		bit_is(seen, 1'b1);
		rd(SB, 16'h0048);
		out_queue_avail = 1'b1;
		@(negedge clk);
		bit_is(status_byte[STB_MAV], 1'b1);
		wr(EE, 16'h0001);
		std_evt = 8'h01;
		@(negedge clk);
		std_evt = 8'h00;
		@(negedge clk);
		bit_is(status_byte[STB_ESB], 1'b1);
		rd(ES, 16'h0001);
		bit_is(status_byte[STB_ESB], 1'b0);
		err_code = 16'h0011;
		err_push = 1'b1;
		@(negedge clk);
		err_code = 16'h0022;
		@(negedge clk);
		err_push = 1'b0;
		bit_is(status_byte[STB_ERRQ], 1'b1);
		rd(EQ, 16'h0011);
		rd(EQ, 16'h0022);
		rd(EQ, ERRQ_EMPTY);
		// Seventeen pushes into sixteen slots: the last one is dropped
		err_push = 1'b1;
		for (int i = 1; i <= 17; i++)
		begin
			err_code = 16'(i);
			@(negedge clk);
		end
		err_push = 1'b0;
		bit_is(err_full, 1'b1);
		rd(EQ, 16'h0001);
		bit_is(err_full, 1'b0);
		rd(QE, 16'h0001);
		ques_cond = 15'h0007;
		repeat (3) @(negedge clk);
		rd(QE, 16'h0000);
		// Filtered fall lands in the very cycle of the clearing read
		fork
			rd(QE, 16'h0000);
			begin
				@(negedge clk);
				ques_cond = 15'h0005;
			end
		join
		rd(QE, 16'h0002);
		// Operation register: a filtered rise reaches status byte bit 7
		oper_cond = 15'h7ffe;
		repeat (2) @(negedge clk);
		oper_cond = 15'h7fff;
		@(negedge clk);
		wr(OM, 16'h0001);
		bit_is(status_byte[STB_OPER], 1'b1);
		rd(OE, 16'h0001);
		bit_is(status_byte[STB_OPER], 1'b0);
		rd(5'h1f, 16'h0000);
		finish_test();
	end
endmodule // tb_ssr_unit
